// ==== rtl/acl_action_pkg.sv ====
package acl_action_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACT_A    = 8'h0a;
  localparam logic [7:0] IDX_ACT_B    = 8'h0b;
  localparam logic [7:0] IDX_MASK_HI  = 8'h0c;
  localparam logic [7:0] IDX_MASK_LO  = 8'h0d;
  localparam logic [7:0] IDX_CTRL     = 8'h20;
  localparam logic [7:0] IDX_ISTAT    = 8'h21;
  localparam logic [7:0] IDX_IMASK    = 8'h22;
  localparam logic [7:0] IDX_COUNT    = 8'h23;

  // Action byte A fields
  localparam int A_REMARK_EN  = 2;
  localparam int A_RP_HI_LSB  = 0;
  // Action byte B fields
  localparam int B_RP_LO      = 7;
  localparam int B_MM_LSB     = 5;
  localparam int B_MAP_LSB    = 0;
  localparam int MAP_UNIT_BIT = 4;
  localparam int MAP_DIR_BIT  = 3;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ENB_LSB  = 2;
  // Interrupt status bits
  localparam int IRQ_EXPIRED  = 0;
  localparam int IRQ_REACHED  = 1;

  localparam logic [7:0] ACT_A_RST   = 8'h00;
  localparam logic [7:0] ACT_B_RST   = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [1:0] MODE_COUNT  = 2'h1;
  localparam logic [1:0] ENB_COUNT   = 2'h0;
  localparam logic [4:0] MAP_RSVD    = 5'h08;

  localparam logic [1:0] MM_LUT      = 2'h0;
  localparam logic [1:0] MM_OR       = 2'h1;
  localparam logic [1:0] MM_AND      = 2'h2;
  localparam logic [1:0] MM_ENTRY    = 2'h3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int MS_US         = 1000;
  localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic       match;
    logic [2:0] prio;
    logic [4:0] lut_map;
  } pkt_in_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] prio;
    logic [4:0] map;
  } pkt_out_s;

endpackage

// ==== rtl/acl_entry_action_logic.sv ====
`timescale 1ns/10ps
module acl_entry_action_logic (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire acl_action_pkg::pkt_in_s  pkt_in,
  output acl_action_pkg::pkt_out_s      pkt_out,
  output logic [15:0]                   cascade_mask,
  output logic                          irq
);

  typedef struct packed {
    logic                     pend_wr;
    logic [7:0]               pend_idx;
    logic [7:0]               act_a;
    logic [7:0]               act_b;
    logic [7:0]               mask_hi;
    logic [7:0]               mask_lo;
    logic [1:0]               entry_mode_field;
    logic [1:0]               entry_enable_field;
    logic [1:0]               istat;
    logic [1:0]               imask;
    logic [10:0]              cnt;
    logic [6:0]               us_div;
    logic [9:0]               ms_div;
    logic [31:0]              rdata;
    acl_action_pkg::pkt_out_s out;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Count value spread over the action fields
  function automatic logic [10:0] count_target(input logic [7:0] a,
                                               input logic [7:0] b);
    count_target = {a, b[acl_action_pkg::B_RP_LO],
                    b[acl_action_pkg::B_MM_LSB +: 2]};
  endfunction

  function automatic logic [4:0] merge_map(input logic [1:0] mm,
                                           input logic [4:0] entry,
                                           input logic [4:0] lut);
    logic [4:0] e;
    e = entry & ~acl_action_pkg::MAP_RSVD;
    unique case (mm)
      acl_action_pkg::MM_LUT:   merge_map = lut;
      acl_action_pkg::MM_OR:    merge_map = e | lut;
      acl_action_pkg::MM_AND:   merge_map = e & lut;
      acl_action_pkg::MM_ENTRY: merge_map = e;
    endcase
  endfunction

  function automatic logic [31:0] read_reg(input state_s s,
                                           input logic [7:0] idx);
    read_reg = 32'h0000_0000;
    unique case (idx)
      acl_action_pkg::IDX_ACT_A:   read_reg[7:0] = s.act_a;
      acl_action_pkg::IDX_ACT_B:   read_reg[7:0] = s.act_b;
      acl_action_pkg::IDX_MASK_HI: read_reg[7:0] = s.mask_hi;
      acl_action_pkg::IDX_MASK_LO: read_reg[7:0] = s.mask_lo;
      acl_action_pkg::IDX_CTRL: begin
        read_reg[acl_action_pkg::CTRL_MODE_LSB +: 2] = s.entry_mode_field;
        read_reg[acl_action_pkg::CTRL_ENB_LSB +: 2]  = s.entry_enable_field;
      end
      acl_action_pkg::IDX_ISTAT:   read_reg[1:0] = s.istat;
      acl_action_pkg::IDX_IMASK:   read_reg[1:0] = s.imask;
      acl_action_pkg::IDX_COUNT:   read_reg[10:0] = s.cnt;
      default:                     read_reg = 32'h0000_0000;
    endcase
  endfunction

  logic        addr_ok;
  logic [7:0]  addr_idx;
  logic        counter_use;
  logic        count_up;
  logic        unit_ms;
  logic [10:0] target;
  logic        us_tick;
  logic        ms_tick;
  logic        tick;
  logic        arm;
  logic [1:0]  ev;
  logic [2:0]  remark_prio;

  always_comb begin
    st_nxt = st_r;
    ev     = 2'h0;
    arm    = 1'b0;

    addr_ok  = hsel && hready && (htrans == acl_action_pkg::HTRANS_NONSEQ ||
                                  htrans == acl_action_pkg::HTRANS_SEQ);
    addr_idx = haddr[9:2];

    // Data phase of a write
    if (st_r.pend_wr) begin
      arm = 1'b1;
      unique case (st_r.pend_idx)
        acl_action_pkg::IDX_ACT_A:   st_nxt.act_a = hwdata[7:0];
        acl_action_pkg::IDX_ACT_B:   st_nxt.act_b = hwdata[7:0];
        acl_action_pkg::IDX_MASK_HI: st_nxt.mask_hi = hwdata[7:0];
        acl_action_pkg::IDX_MASK_LO: st_nxt.mask_lo = hwdata[7:0];
        acl_action_pkg::IDX_CTRL: begin
          st_nxt.entry_mode_field =
            hwdata[acl_action_pkg::CTRL_MODE_LSB +: 2];
          st_nxt.entry_enable_field =
            hwdata[acl_action_pkg::CTRL_ENB_LSB +: 2];
        end
        acl_action_pkg::IDX_IMASK: st_nxt.imask = hwdata[1:0];
        acl_action_pkg::IDX_ISTAT: begin
          st_nxt.istat = st_r.istat & ~hwdata[1:0];
          arm = 1'b0;
        end
        default: arm = 1'b0;
      endcase
    end

    counter_use = st_nxt.entry_mode_field == acl_action_pkg::MODE_COUNT &&
                  st_nxt.entry_enable_field == acl_action_pkg::ENB_COUNT;
    count_up    = st_nxt.act_b[acl_action_pkg::MAP_DIR_BIT];
    unit_ms     = st_nxt.act_b[acl_action_pkg::MAP_UNIT_BIT];
    target      = count_target(st_nxt.act_a, st_nxt.act_b);

    // Time base: microsecond and millisecond enables
    us_tick = st_r.us_div == 7'(acl_action_pkg::US_CYCLES - 1);
    ms_tick = us_tick && st_r.ms_div == 10'(acl_action_pkg::MS_US - 1);
    st_nxt.us_div = us_tick ? 7'h00 : 7'(st_r.us_div + 7'h01);
    if (us_tick) begin
      st_nxt.ms_div = ms_tick ? 10'h000 : 10'(st_r.ms_div + 10'h001);
    end
    tick = unit_ms ? ms_tick : us_tick;

    // Counter; a configuration write restarts it
    if (!counter_use || arm) begin
      st_nxt.cnt = count_up ? 11'h000 : target;
    end else if (count_up) begin
      if (pkt_in.match) begin
        if (11'(st_r.cnt + 11'h001) >= target) begin
          st_nxt.cnt = 11'h000;
          ev[acl_action_pkg::IRQ_REACHED] = 1'b1;
        end else begin
          st_nxt.cnt = 11'(st_r.cnt + 11'h001);
        end
      end
    end else if (tick) begin
      if (st_r.cnt <= 11'h001) begin
        st_nxt.cnt = target;
        ev[acl_action_pkg::IRQ_EXPIRED] = 1'b1;
      end else begin
        st_nxt.cnt = 11'(st_r.cnt - 11'h001);
      end
    end

    // Hardware set wins over a software clear
    st_nxt.istat = st_nxt.istat | ev;

    // Packet action; counter use borrows the action fields
    remark_prio = {st_nxt.act_a[acl_action_pkg::A_RP_HI_LSB +: 2],
                   st_nxt.act_b[acl_action_pkg::B_RP_LO]};
    st_nxt.out.valid = pkt_in.match;
    if (pkt_in.match) begin
      if (counter_use) begin
        st_nxt.out.prio = pkt_in.prio;
        st_nxt.out.map  = pkt_in.lut_map;
      end else begin
        st_nxt.out.prio = st_nxt.act_a[acl_action_pkg::A_REMARK_EN] ?
                          remark_prio : pkt_in.prio;
        st_nxt.out.map  = merge_map(
          st_nxt.act_b[acl_action_pkg::B_MM_LSB +: 2],
          st_nxt.act_b[acl_action_pkg::B_MAP_LSB +: 5],
          pkt_in.lut_map);
      end
    end

    // Address phase; read data taken after any pending write
    st_nxt.pend_wr  = addr_ok && hwrite;
    st_nxt.pend_idx = addr_idx;
    if (addr_ok && !hwrite) begin
      st_nxt.rdata = read_reg(st_nxt, addr_idx);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.pend_wr            <= 1'b0;
      st_r.pend_idx           <= 8'h00;
      st_r.act_a              <= acl_action_pkg::ACT_A_RST;
      st_r.act_b              <= acl_action_pkg::ACT_B_RST;
      st_r.mask_hi            <= acl_action_pkg::MASK_RST;
      st_r.mask_lo            <= acl_action_pkg::MASK_RST;
      st_r.entry_mode_field   <= 2'h0;
      st_r.entry_enable_field <= 2'h0;
      st_r.istat              <= 2'h0;
      st_r.imask              <= 2'h0;
      st_r.cnt                <= 11'h000;
      st_r.us_div             <= 7'h00;
      st_r.ms_div             <= 10'h000;
      st_r.rdata              <= 32'h0000_0000;
      st_r.out                <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st_r.rdata;
  assign pkt_out      = st_r.out;
  assign cascade_mask = {st_r.mask_hi, st_r.mask_lo};
  assign irq          = |(st_r.istat & st_r.imask);

endmodule

// ==== sim/acl_entry_action_logic_properties.sv ====
`timescale 1ns/10ps
module acl_entry_action_props (
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire logic                     hsel,
  input wire logic [31:0]              haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic [2:0]               hsize,
  input wire logic [31:0]              hwdata,
  input wire logic                     hready,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  input wire logic [31:0]              hrdata,
  input wire acl_action_pkg::pkt_in_s  pkt_in,
  input wire acl_action_pkg::pkt_out_s pkt_out,
  input wire logic [15:0]              cascade_mask,
  input wire logic                     irq
);
  logic       pend_r;
  logic [7:0] idx_r, a_r, b_r, hi_r, lo_r, ctrl_r;
  logic       cu;
  logic [4:0] em;
  assign cu = ctrl_r[3:0] == 4'h1;
  assign em = b_r[4:0] & ~acl_action_pkg::MAP_RSVD;
  // Shadow of the action registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      idx_r <= 8'h00;
      {a_r, b_r, hi_r, lo_r, ctrl_r} <= 40'h0;
    end else begin
      pend_r <= hsel && hready && htrans[1] && hwrite;
      idx_r <= haddr[9:2];
      if (pend_r) begin
        case (idx_r)
          acl_action_pkg::IDX_ACT_A:   a_r <= hwdata[7:0];
          acl_action_pkg::IDX_ACT_B:   b_r <= hwdata[7:0];
          acl_action_pkg::IDX_MASK_HI: hi_r <= hwdata[7:0];
          acl_action_pkg::IDX_MASK_LO: lo_r <= hwdata[7:0];
          acl_action_pkg::IDX_CTRL:    ctrl_r <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  valid_follow_a: assert property (pkt_in.match |=> pkt_out.valid)
    else $error("Result missing after match");
  valid_pulse_a: assert property (!pkt_in.match |=> !pkt_out.valid)
    else $error("Result without match");
  prio_mark_a: assert property (pkt_out.valid && !cu |-> pkt_out.prio ==
    (a_r[2] ? {a_r[1:0], b_r[7]} : $past(pkt_in.prio)))
    else $error("Priority wrong");
  map_lut_a: assert property (pkt_out.valid && !cu && b_r[6:5] == 2'h0
    |-> pkt_out.map == $past(pkt_in.lut_map)) else $error("Map lut wrong");
  map_or_a: assert property (pkt_out.valid && !cu && b_r[6:5] == 2'h1
    |-> pkt_out.map == (em | $past(pkt_in.lut_map))) else $error("Map or");
  map_and_a: assert property (pkt_out.valid && !cu && b_r[6:5] == 2'h2
    |-> pkt_out.map == (em & $past(pkt_in.lut_map))) else $error("Map and");
  map_entry_a: assert property (pkt_out.valid && !cu && b_r[6:5] == 2'h3
    |-> pkt_out.map == em) else $error("Map entry wrong");
  count_pass_a: assert property (pkt_out.valid && cu |-> pkt_out ==
    {1'b1, $past(pkt_in.prio), $past(pkt_in.lut_map)}) else $error("Pass");
  mask_out_a: assert property (cascade_mask == {hi_r, lo_r})
    else $error("Cascade mask wrong");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("Bus not ready or error");
endmodule
bind acl_entry_action_logic acl_entry_action_props u_props (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .pkt_in, .pkt_out, .cascade_mask, .irq);

// ==== sim/acl_entry_action_logic_tb.sv ====
`timescale 1ns/10ps
module acl_entry_action_logic_tb;
  logic                     hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  logic [31:0]              haddr, hwdata, hrdata, q;
  logic [15:0]              cascade_mask;
  acl_action_pkg::pkt_in_s  pkt_in;
  acl_action_pkg::pkt_out_s pkt_out;
  integer                   n_errors, n_checks, seed, i, j, ra, rb, pr, lut, em;
  logic [7:0]               idxs [9] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h20,
                                         8'h21, 8'h22, 8'h23, 8'h40};
  acl_entry_action_logic dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pkt_in,
    .pkt_out, .cascade_mask, .irq);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= acl_action_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask
  task automatic pkt(input logic [2:0] p, input logic [4:0] l);
    @(posedge hclk);
    pkt_in <= {1'b1, p, l};
    @(posedge hclk);
    pkt_in <= '0;
    #1;
  endtask
  task automatic wait_irq(input integer lim);
    i = 0;
    while (irq !== 1'b1 && i < lim) begin
      @(posedge hclk);
      #1;
      i++;
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    wrap_up;
  end
  initial begin
    {seed, n_errors, n_checks} = {32'd3, 64'd0};
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    pkt_in = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, 8'h40, 8'hff);
    for (j = 0; j < 9; j++) begin
      xfer(1'b0, idxs[j], 8'h00);
      chk(q, 0);
    end
    pr = $random(seed) & 16'hffff;
    xfer(1'b1, acl_action_pkg::IDX_MASK_HI, pr[15:8]);
    xfer(1'b1, acl_action_pkg::IDX_MASK_LO, pr[7:0]);
    chk(cascade_mask, pr);
    xfer(1'b0, acl_action_pkg::IDX_MASK_HI, 8'h00);
    chk(q, pr[15:8]);
    $display("Register test done");
    for (j = 0; j < 8; j++) begin
      ra = $random(seed) & 8'hff;
      rb = $random(seed) & 8'hff;
      ra[2] = j[0];
      rb[6:5] = j[2:1];
      pr = $random(seed) & 7;
      lut = $random(seed) & 31;
      em = rb & 5'h17;
      xfer(1'b1, acl_action_pkg::IDX_ACT_A, ra[7:0]);
      xfer(1'b1, acl_action_pkg::IDX_ACT_B, rb[7:0]);
      pkt(pr[2:0], lut[4:0]);
      chk(pkt_out.prio, ra[2] ? {ra[1:0], rb[7]} : pr);
      chk(pkt_out.map, j[2:1] == 0 ? lut : j[2:1] == 1 ? em | lut :
          j[2:1] == 2 ? em & lut : em);
    end
    $display("Forwarding test done");
    xfer(1'b1, acl_action_pkg::IDX_IMASK, 8'h01);
    xfer(1'b1, acl_action_pkg::IDX_ACT_A, 8'h00);
    xfer(1'b1, acl_action_pkg::IDX_ACT_B, 8'h60);
    xfer(1'b1, acl_action_pkg::IDX_CTRL, 8'h01);
    pkt(3'h5, 5'h1f);
    chk(pkt_out, 9'h1bf);
    wait_irq(500);
    chk(i > 190 && i <= 300, 1);
    xfer(1'b1, acl_action_pkg::IDX_IMASK, 8'h00);
    repeat (400) @(posedge hclk);
    #1;
    chk(irq, 0);
    xfer(1'b0, acl_action_pkg::IDX_ISTAT, 8'h00);
    chk(q, 1);
    $display("Down count test done");
    xfer(1'b1, acl_action_pkg::IDX_ACT_B, 8'h68);
    xfer(1'b1, acl_action_pkg::IDX_ISTAT, 8'h03);
    xfer(1'b1, acl_action_pkg::IDX_IMASK, 8'h02);
    chk(irq, 0);
    pkt(3'h0, 5'h00);
    pkt(3'h0, 5'h00);
    xfer(1'b0, acl_action_pkg::IDX_COUNT, 8'h00);
    chk(q, 2);
    chk(irq, 0);
    pkt(3'h0, 5'h00);
    wait_irq(3);
    chk(irq, 1);
    $display("Up count test done");
    wrap_up;
  end
endmodule
